// ===== core/chgind_pkg.sv
`default_nettype none
package chgind_pkg;
    // =====================================================
    // Output pin levels
    localparam logic PIN_ASSERT  = 1'b0;
    localparam logic PIN_RELEASE = 1'b1;
    // =====================================================
    // Synchroniser depth for comparator pins
    localparam int SYNC_STAGES = 3;
    // =====================================================
    // Comparator bit positions
    localparam int CMP_UVLO_BIT  = 0;
    localparam int CMP_SLEEP_BIT = 1;
    localparam int CMP_OVP_BIT   = 2;
    localparam int CMP_COUNT     = 3;
    // =====================================================
    // Charge-status states
    typedef enum logic [1:0] {
        CHGIND_IDLE  = 2'b00,
        CHGIND_FIRST = 2'b01,
        CHGIND_DONE  = 2'b10
    } chgind_state_e;
endpackage
`default_nettype wire

// ===== core/chgind_top.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Input good low only inside valid window
// - Release input good on UVLO, sleep, OVP
// - New cycle drives charge status low
// - After termination stay released until new cycle
// - Recharge cycles never assert charge status
// - Thermal suspend keeps current output level
// - Timer restart counts as new cycle
module chgind_top (
    // Clock, reset, enable
    input  wire logic core_clk_in,
    input  wire logic arst_n_in,
    input  wire logic clk_en_in,
    // Comparator results (asynchronous)
    input  wire logic above_uvlo_in,
    input  wire logic above_sleep_in,
    input  wire logic above_ovp_in,
    // Charger events (same clock)
    input  wire logic new_cycle_in,
    input  wire logic timer_restart_in,
    input  wire logic terminate_in,
    input  wire logic recharge_in,
    input  wire logic thermal_suspend_in,
    input  wire logic timer_fault_in,
    input  wire logic battery_absent_in,
    // Open-drain status pins
    output logic      input_good_n_out,
    output logic      input_good_n_oe_out,
    output logic      charge_active_n_out,
    output logic      charge_active_n_oe_out
);
    // =====================================================
    // Comparator synchronisers
    localparam int NCMP = chgind_pkg::CMP_COUNT;
    logic [NCMP-1:0] cmp_raw;
    logic [NCMP-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    logic [NCMP-1:0] s1_next, s2_next, s3_next, filt_next;
    assign cmp_raw = {above_ovp_in, above_sleep_in, above_uvlo_in};

    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi++) begin : g_cmp
            // Stage one feeds stage two only; agreement of two and three filters glitches
            always_comb begin
                s1_next[gi]   = cmp_raw[gi];
                s2_next[gi]   = s1_reg[gi];
                s3_next[gi]   = s2_reg[gi];
                filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
        end else if (clk_en_in) begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            s3_reg   <= s3_next;
            filt_reg <= filt_next;
        end
    end

    // =====================================================
    // Input good
    logic supply_ok;
    logic ig_reg, ig_next;
    // Sleep comparator already includes battery plus offset
    assign supply_ok = filt_reg[chgind_pkg::CMP_UVLO_BIT]
                     & filt_reg[chgind_pkg::CMP_SLEEP_BIT]
                     & ~filt_reg[chgind_pkg::CMP_OVP_BIT];

    always_comb begin
        ig_next = supply_ok ? chgind_pkg::PIN_ASSERT : chgind_pkg::PIN_RELEASE;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ig_reg <= chgind_pkg::PIN_RELEASE;
        end else if (clk_en_in) begin
            ig_reg <= ig_next;
        end
    end

    // =====================================================
    // Charge status
    chgind_pkg::chgind_state_e st_reg, st_next;
    logic cs_reg, cs_next;
    logic start_ev, kill_ev;
    assign start_ev = new_cycle_in | timer_restart_in;
    // Kill outranks start so a fault never flashes the pin
    assign kill_ev  = timer_fault_in | battery_absent_in | ~supply_ok;

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            chgind_pkg::CHGIND_IDLE: begin
                if (start_ev && !kill_ev) begin
                    st_next = chgind_pkg::CHGIND_FIRST;
                end
            end
            chgind_pkg::CHGIND_FIRST: begin
                // Restart wins over a same-cycle termination
                if (kill_ev) begin
                    st_next = chgind_pkg::CHGIND_IDLE;
                end else if (start_ev) begin
                    st_next = chgind_pkg::CHGIND_FIRST;
                end else if (terminate_in) begin
                    st_next = chgind_pkg::CHGIND_DONE;
                end else begin
                    st_next = chgind_pkg::CHGIND_FIRST;
                end
            end
            chgind_pkg::CHGIND_DONE: begin
                // Recharge is ignored; only a fresh start or a kill leaves
                if (start_ev && !kill_ev) begin
                    st_next = chgind_pkg::CHGIND_FIRST;
                end else if (kill_ev) begin
                    st_next = chgind_pkg::CHGIND_IDLE;
                end
            end
            default: st_next = chgind_pkg::CHGIND_IDLE;
        endcase
        cs_next = (st_next == chgind_pkg::CHGIND_FIRST) ? chgind_pkg::PIN_ASSERT
                                                        : chgind_pkg::PIN_RELEASE;
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg <= chgind_pkg::CHGIND_IDLE;
            cs_reg <= chgind_pkg::PIN_RELEASE;
        end else if (clk_en_in) begin
            st_reg <= st_next;
            cs_reg <= cs_next;
        end
    end

    // Open drain: pin only ever driven low
    assign input_good_n_out       = chgind_pkg::PIN_ASSERT;
    assign input_good_n_oe_out    = (ig_reg == chgind_pkg::PIN_ASSERT);
    assign charge_active_n_out    = chgind_pkg::PIN_ASSERT;
    assign charge_active_n_oe_out = (cs_reg == chgind_pkg::PIN_ASSERT);

    // =====================================================
    // Assertions
    ig_window_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_en_in |=> (input_good_n_oe_out == $past(supply_ok)))
        else $error("input good enable does not follow window");

    ig_ovp_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && filt_reg[chgind_pkg::CMP_OVP_BIT]) |=> !input_good_n_oe_out)
        else $error("input good driven during overvoltage");

    ig_uvlo_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !filt_reg[chgind_pkg::CMP_UVLO_BIT]) |=> !input_good_n_oe_out)
        else $error("input good driven below lockout");

    ig_sleep_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !filt_reg[chgind_pkg::CMP_SLEEP_BIT]) |=> !input_good_n_oe_out)
        else $error("input good driven below sleep level");

    cs_start_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && start_ev && !kill_ev) |=> charge_active_n_oe_out)
        else $error("charge status not asserted on new cycle");

    cs_term_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && terminate_in && !start_ev) |=> !charge_active_n_oe_out)
        else $error("charge status still low after termination");

    cs_done_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && st_reg == chgind_pkg::CHGIND_DONE && !start_ev) |=> !charge_active_n_oe_out)
        else $error("charge status low after done without new cycle");

    cs_recharge_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && !charge_active_n_oe_out && !start_ev) |=> !charge_active_n_oe_out)
        else $error("charge status asserted without new cycle");

    recharge_ignored_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && recharge_in && !start_ev && !charge_active_n_oe_out) |=> !charge_active_n_oe_out)
        else $error("charge status asserted by recharge");

    cs_thermal_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && thermal_suspend_in && charge_active_n_oe_out && !kill_ev && !terminate_in)
        |=> charge_active_n_oe_out)
        else $error("charge status dropped during thermal suspend");

    cs_fault_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && kill_ev) |=> !charge_active_n_oe_out)
        else $error("charge status low during fault");

    cs_restart_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        (clk_en_in && timer_restart_in && !kill_ev) |=> charge_active_n_oe_out)
        else $error("timer restart not treated as new cycle");

    ig_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !clk_en_in |=> $stable(input_good_n_oe_out))
        else $error("state moved while disabled");

    cs_hold_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        !clk_en_in |=> $stable(charge_active_n_oe_out))
        else $error("charge status moved while disabled");

    sync_agree_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_en_in |=> (((filt_reg ^ $past(filt_reg)) & $past(s2_reg ^ s3_reg)) == '0))
        else $error("comparator changed before two stages agreed");

    // =====================================================
    // Cover points
    cov_first_c: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        $rose(charge_active_n_oe_out));

    cov_done_c: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        st_reg == chgind_pkg::CHGIND_DONE && recharge_in);

    cov_ig_c: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        $rose(input_good_n_oe_out));

    cov_restart_c: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_en_in && timer_restart_in && st_reg == chgind_pkg::CHGIND_DONE);

    cov_thermal_c: cover property (@(posedge core_clk_in) disable iff (!arst_n_in)
        clk_en_in && thermal_suspend_in && charge_active_n_oe_out);
endmodule
`default_nettype wire

// ===== sim/chgind_pullup.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Pull-up on an open-drain pin
// Released pin reads high, never the last level
module chgind_pullup (
    // Driver side
    input  wire logic data_in,
    input  wire logic oe_in,
    // Wire level
    output logic      pin_out
);
    assign pin_out = oe_in ? data_in : 1'b1;
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==========================================
    // Stimulus, pins and model state
    logic        core_clk_in = 1'b0;
    logic        arst_n_in   = 1'b0;
    logic        clk_en_in   = 1'b1;
    logic [9:0]  drv         = 10'h000;
    logic [31:0] lf          = 32'h74296D4D;
    logic [2:0]  c;
    logic        ig_d, ig_oe, ca_d, ca_oe, ig_pin, ca_pin;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    bit          act         = 1'b0;
    bit          ok          = 1'b0;
    always #2.5 core_clk_in = ~core_clk_in;
    chgind_top uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
        .above_uvlo_in(drv[0]), .above_sleep_in(drv[1]), .above_ovp_in(drv[2]),
        .new_cycle_in(drv[3]), .timer_restart_in(drv[4]), .terminate_in(drv[5]),
        .recharge_in(drv[6]), .thermal_suspend_in(drv[7]), .timer_fault_in(drv[8]),
        .battery_absent_in(drv[9]), .input_good_n_out(ig_d), .input_good_n_oe_out(ig_oe),
        .charge_active_n_out(ca_d), .charge_active_n_oe_out(ca_oe));
    chgind_pullup pu_ig (.data_in(ig_d), .oe_in(ig_oe), .pin_out(ig_pin));
    chgind_pullup pu_ca (.data_in(ca_d), .oe_in(ca_oe), .pin_out(ca_pin));
    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task automatic chk(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One event pulse; kind 7 is a start while the clock enable is low
    task automatic ev(input int k);
        @(posedge core_clk_in);
        clk_en_in <= (k != 7);
        drv[(k == 7) ? 3 : 3 + k] <= 1'b1;
        if (k != 7) begin
            if (k == 5 || k == 6 || !ok)
                act = 1'b0;
            else if (k < 2)
                act = 1'b1;
            else if (k == 2)
                act = 1'b0;
        end
        @(posedge core_clk_in);
        drv[9:3] <= 7'h00;
        clk_en_in <= 1'b1;
        @(negedge core_clk_in);
        chk(!act, ca_pin);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk_in);
        @(negedge core_clk_in);
        chk(1'b1, ig_pin);
        chk(1'b1, ca_pin);
        @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        for (int t = 0; t < 40; t++) begin
            lf = lfsr_next(lf);
            // Bias towards a valid supply so starts are not mostly killed
            c = (lf[4:3] == 2'h0) ? lf[2:0] : 3'h3;
            ok = c[0] && c[1] && !c[2];
            if (!ok)
                act = 1'b0;
            @(posedge core_clk_in);
            drv[2:0] <= c;
            repeat (8) @(posedge core_clk_in);
            @(negedge core_clk_in);
            chk(!ok, ig_pin);
            chk(!act, ca_pin);
            for (int e = 0; e < 6; e++) begin
                lf = lfsr_next(lf);
                ev(int'(lf[10:8]));
            end
            $display("test %0d done", t);
        end
        results();
    end
    // Run needs about 1000 cycles; allow twenty times that
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
